// [rsq_core.sv]
// Start-up sequencer, temperature handling and current compensation core.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`include "rsq_map.svh"
`default_nettype none
// Operation
// - Each rail reports the hottest stage reading on its temperature input.
// - Rail 0 stages use the first input, rail 1 stages the second.
// - Die temperature is measured and readable as telemetry.
// - Temperatures feed telemetry and, for rail 0 only, current compensation.
// - Winding temperature equals gain times sensor temperature plus offset.
// - Corrected resistance is nominal times one plus 3900 ppm times (T minus 25).
// - Phase current is computed with the corrected winding resistance.
// - Input current synthesized with offset and gain; power from current and voltage.
// - After power-on the core regulator starts, checks run, profile and limits load.
// - Shutdown state entered only once supply good and input above INPUT_UNDERVOLTAGE_LOCKOUT threshold.
// - From shutdown, a rail goes active and soft-starts when its enable asks.
// - In shutdown all phase modulation outputs are released to high impedance.
// - Soft-start delay runs from enable to expiry, then the programmed ramp follows.
// - Ramp-up, ramp-down and delay are set independently per rail.
// - About 200 microseconds of initialisation precede each ramp-up; a ramp-down starts without it.
// - A zero ramp setting steps the target at once.
// - Eight profiles 0 to 7; load the one named by the select resistor.
// - AC feedback holds output flat; droop follows the programmed resistance.
// - Latest save per identifier is loaded; at most eight saves total.
module rsq_core #(
    parameter int INIT_CYC = `RSQ_INIT_CYC,
    parameter int NPH = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_good,
    input wire logic [15:0] input_voltage_sense_pin,
    input wire logic [2:0] profile_resistor_code,
    input wire logic [1:0] rail_enable_pins,
    input wire logic [15:0] rail0_temp_input_a,
    input wire logic [15:0] rail0_temp_input_b,
    input wire logic [15:0] rail1_temp_input_a,
    input wire logic [15:0] rail1_temp_input_b,
    input wire logic [15:0] die_temp,
    input wire logic [15:0] sensed_phase_voltage,
    output logic internal_core_regulator_en,
    output logic telemetry_en,
    output logic [NPH-1:0] pwm_out,
    output logic [NPH-1:0] pwm_oe,
    output logic [15:0] rail0_target,
    output logic [15:0] rail1_target,
    output logic [1:0] rail_feedback_droop
);
    import rsq_pkg::*;

    // =====================================================================
    // State
    typedef struct packed {
        rsq_top_type top;
        logic [2:0] sync1_code;
        logic [2:0] sync2_code;
        logic [1:0] sync1_en;
        logic [1:0] sync2_en;
        logic [1:0] sync1_sup;
        logic [1:0] sync2_sup;
        logic [2:0] prof_id;
        logic [3:0] saves;
        logic [7:0] saved_mask;
        logic [15:0] input_undervoltage_lockout;
        logic [15:0] gain;
        logic [15:0] offset;
        logic [15:0] dcr25;
        logic [15:0] winding_resistance_corrected;
        logic [15:0] inc_gain;
        logic [15:0] inc_off;
        logic [31:0] inpwr;
        logic [15:0] cur;
        logic [1:0] droop;
        logic [63:0] seq;
        rsq_rail_type [1:0] rail;
        logic [1:0][31:0] cnt;
        logic [1:0][15:0] target;
        logic [15:0] t0;
        logic [15:0] t1;
        logic [15:0] tdie;
        logic [31:0] rdata;
        logic ready;
        logic pwm_drive;
    } rsq_state_type;

    rsq_state_type s_q, s_d;

    // =====================================================================
    // Helpers
    function automatic logic [15:0] tmax(input logic [15:0] a, input logic [15:0] b);
        tmax = ($signed(a) > $signed(b)) ? a : b;
    endfunction

    function automatic logic [15:0] qmul(input logic [15:0] a, input logic [15:0] b);
        logic [31:0] p;
        p = 32'($signed(a) * $signed(b));
        qmul = p[23:8];
    endfunction

    // Fixed table from the select resistor bin to a profile identifier.
    function automatic logic [2:0] code_to_id(input logic [2:0] c);
        logic [2:0] id;
        id = 3'h0;
        unique case (c)
            3'h0: id = 3'h1;
            3'h1: id = 3'h2;
            3'h2: id = 3'h3;
            3'h3: id = 3'h4;
            3'h4: id = 3'h5;
            3'h5: id = 3'h6;
            3'h6: id = 3'h7;
            3'h7: id = 3'h0;
        endcase
        code_to_id = id;
    endfunction

    logic [15:0] twind;
    logic [31:0] dcr_prod;
    logic [15:0] dtemp;
    logic acc_w;
    logic acc_r;

    assign acc_w = psel && penable && pwrite;
    assign acc_r = psel && penable && !pwrite;

    // =====================================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.sync1_code = profile_resistor_code;
        s_d.sync2_code = s_q.sync1_code;
        s_d.sync1_en = rail_enable_pins;
        s_d.sync2_en = s_q.sync1_en;
        s_d.sync1_sup = {1'b0, supply_good};
        s_d.sync2_sup = s_q.sync1_sup;
        s_d.ready = psel && penable && !s_q.ready;
        // Temperatures are always live so telemetry and current compensation see them.
        s_d.t0 = tmax(rail0_temp_input_a, rail0_temp_input_b);
        s_d.t1 = tmax(rail1_temp_input_a, rail1_temp_input_b);
        s_d.tdie = die_temp;
        twind = 16'(qmul(s_q.gain, s_q.t0) + s_q.offset);
        dtemp = 16'(twind - 16'(`RSQ_REF_DEGC << 8));
        dcr_prod = 32'($signed(dtemp) * 32'sd`RSQ_TC_PPM);
        // Q8.8 degrees times ppm over a million is the Q8.8 change; the nominal stays unsigned.
        dcr_prod = 32'(16'($signed(dcr_prod) / 32'sd1000000));
        dcr_prod = 32'($signed({16'h0, s_q.dcr25}) * $signed(dcr_prod[15:0]));
        s_d.winding_resistance_corrected = 16'(s_q.dcr25 + dcr_prod[23:8]);
        s_d.cur = 16'(({16'h0, sensed_phase_voltage} << 8)
            / {16'h0, (s_q.winding_resistance_corrected == 16'h0) ? 16'h1 : s_q.winding_resistance_corrected});
        s_d.inpwr = 32'(qmul(s_q.cur, s_q.inc_gain) + s_q.inc_off)
            * 32'(input_voltage_sense_pin);

        unique case (s_q.top)
            RSQ_POR: if (s_q.sync2_sup[0]) begin
                s_d.top = RSQ_LOAD;
            end
            RSQ_LOAD: begin
                // Identifier is fixed once here so a pin glitch later cannot swap profiles.
                s_d.prof_id = code_to_id(s_q.sync2_code);
                s_d.top = RSQ_UVWAIT;
            end
            RSQ_UVWAIT: if (input_voltage_sense_pin >= s_q.input_undervoltage_lockout && s_q.sync2_sup[0]) begin
                s_d.top = RSQ_READY;
            end
            RSQ_READY: if (!s_q.sync2_sup[0]) begin
                s_d.top = RSQ_POR;
            end
        endcase

        for (int r = 0; r < 2; r++) begin
            logic [15:0] dly;
            logic [7:0] up;
            logic [7:0] dn;
            dly = s_q.seq[r*32 +: 16];
            up = s_q.seq[r*32+16 +: 8];
            dn = s_q.seq[r*32+24 +: 8];
            if (s_q.top != RSQ_READY) begin
                s_d.rail[r] = RSQ_OFF;
                s_d.target[r] = 16'h0;
                s_d.cnt[r] = 32'h0;
            end else begin
                unique case (s_q.rail[r])
                    RSQ_OFF: if (s_q.sync2_en[r]) begin
                        s_d.rail[r] = RSQ_DELAY;
                        s_d.cnt[r] = 32'h0;
                    end
                    RSQ_DELAY: begin
                        s_d.cnt[r] = s_q.cnt[r] + 32'h1;
                        if (!s_q.sync2_en[r]) s_d.rail[r] = RSQ_RAMPDN;
                        else if (s_q.cnt[r] >= 32'(dly) * 32'd`RSQ_CLK_MHZ) begin
                            s_d.rail[r] = RSQ_INIT;
                            s_d.cnt[r] = 32'h0;
                        end
                    end
                    RSQ_INIT: begin
                        s_d.cnt[r] = s_q.cnt[r] + 32'h1;
                        if (!s_q.sync2_en[r]) s_d.rail[r] = RSQ_RAMPDN;
                        else if (s_q.cnt[r] >= 32'(INIT_CYC - 1)) begin
                            s_d.rail[r] = RSQ_RAMPUP;
                            s_d.cnt[r] = 32'h0;
                        end
                    end
                    RSQ_RAMPUP: begin
                        s_d.cnt[r] = s_q.cnt[r] + 32'h1;
                        if (!s_q.sync2_en[r]) s_d.rail[r] = RSQ_RAMPDN;
                        else if (up == 8'h0 || s_q.target[r] == 16'hffff) begin
                            s_d.target[r] = 16'hffff;
                            s_d.rail[r] = RSQ_ON;
                        end else if (s_q.cnt[r][7:0] >= up) begin
                            s_d.target[r] = s_q.target[r] + 16'h1;
                            s_d.cnt[r] = 32'h0;
                        end
                    end
                    RSQ_ON: if (!s_q.sync2_en[r]) begin
                        s_d.rail[r] = RSQ_RAMPDN;
                        s_d.cnt[r] = 32'h0;
                    end
                    RSQ_RAMPDN: begin
                        s_d.cnt[r] = s_q.cnt[r] + 32'h1;
                        if (s_q.sync2_en[r]) s_d.rail[r] = RSQ_OFF;
                        else if (dn == 8'h0 || s_q.target[r] == 16'h0) begin
                            s_d.target[r] = 16'h0;
                            s_d.rail[r] = RSQ_OFF;
                        end else if (s_q.cnt[r][7:0] >= dn) begin
                            s_d.target[r] = s_q.target[r] - 16'h1;
                            s_d.cnt[r] = 32'h0;
                        end
                    end
                endcase
            end
        end
        // PWM is driven only while some rail has left the off state.
        s_d.pwm_drive = (s_q.top == RSQ_READY)
            && (s_q.rail[0] != RSQ_OFF || s_q.rail[1] != RSQ_OFF);

        if (acc_w && s_q.ready) begin
            unique case (paddr)
                `RSQ_OFF_CTRL: s_d.droop = pwdata[1:0];
                `RSQ_OFF_INPUT_UNDERVOLTAGE_LOCKOUT: s_d.input_undervoltage_lockout = pwdata[15:0];
                `RSQ_OFF_TCOMP: begin
                    s_d.gain = pwdata[15:0];
                    s_d.offset = pwdata[31:16];
                end
                `RSQ_OFF_DCR: s_d.dcr25 = pwdata[15:0];
                `RSQ_OFF_SEQ0: s_d.seq[31:0] = pwdata;
                `RSQ_OFF_SEQ1: s_d.seq[63:32] = pwdata;
                `RSQ_OFF_INCAL: begin
                    s_d.inc_gain = pwdata[15:0];
                    s_d.inc_off = pwdata[31:16];
                end
                `RSQ_OFF_SAVE: if (s_q.saves < 4'(`RSQ_MAX_SAVES)) begin
                    s_d.saves = s_q.saves + 4'h1;
                    s_d.saved_mask[pwdata[2:0]] = 1'b1;
                end
                default: ;
            endcase
        end
        s_d.rdata = 32'h0;
        if (acc_r && !s_q.ready) begin
            unique case (paddr)
                `RSQ_OFF_CTRL: s_d.rdata = {30'h0, s_q.droop};
                `RSQ_OFF_STATUS: begin
                    s_d.rdata[`RSQ_STAT_SHDN] = s_q.top == RSQ_READY;
                    s_d.rdata[`RSQ_STAT_R0ACT] = s_q.rail[0] != RSQ_OFF;
                    s_d.rdata[`RSQ_STAT_R1ACT] = s_q.rail[1] != RSQ_OFF;
                    s_d.rdata[`RSQ_STAT_PROF_LSB +: 3] = s_q.prof_id;
                    s_d.rdata[`RSQ_STAT_SAVES_LSB +: 4] = s_q.saves;
                end
                `RSQ_OFF_INPUT_UNDERVOLTAGE_LOCKOUT: s_d.rdata = {16'h0, s_q.input_undervoltage_lockout};
                `RSQ_OFF_TCOMP: s_d.rdata = {s_q.offset, s_q.gain};
                `RSQ_OFF_DCR: s_d.rdata = {s_q.winding_resistance_corrected, s_q.dcr25};
                `RSQ_OFF_SEQ0: s_d.rdata = s_q.seq[31:0];
                `RSQ_OFF_SEQ1: s_d.rdata = s_q.seq[63:32];
                `RSQ_OFF_TEMP: s_d.rdata = {s_q.t1, s_q.t0};
                `RSQ_OFF_CUR: s_d.rdata = {s_q.tdie, s_q.cur};
                `RSQ_OFF_INCAL: s_d.rdata = {s_q.inc_off, s_q.inc_gain};
                `RSQ_OFF_INPWR: s_d.rdata = s_q.inpwr;
                `RSQ_OFF_PROFILE: s_d.rdata = {21'h0, s_q.saved_mask, s_q.prof_id};
                default: s_d.rdata = 32'h0;
            endcase
        end
    end

    // =====================================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.top <= RSQ_POR;
            s_q.rail <= {RSQ_OFF, RSQ_OFF};
            s_q.input_undervoltage_lockout <= `RSQ_RST_INPUT_UNDERVOLTAGE_LOCKOUT;
            s_q.gain <= `RSQ_RST_GAIN;
            s_q.offset <= `RSQ_RST_OFFSET;
            s_q.dcr25 <= `RSQ_RST_DCR25;
            s_q.winding_resistance_corrected <= `RSQ_RST_DCR25;
            s_q.inc_gain <= `RSQ_RST_GAIN;
            s_q.seq <= {`RSQ_RST_SEQ, `RSQ_RST_SEQ};
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_core_regulator_en <= 1'b0;
            telemetry_en <= 1'b0;
            pwm_out <= '0;
            pwm_oe <= '0;
            rail0_target <= 16'h0;
            rail1_target <= 16'h0;
            rail_feedback_droop <= 2'h0;
        end else begin
            internal_core_regulator_en <= s_d.top != RSQ_POR;
            telemetry_en <= s_d.top == RSQ_UVWAIT || s_d.top == RSQ_READY;
            pwm_out <= '0;
            pwm_oe <= {NPH{s_d.pwm_drive}};
            rail0_target <= s_d.target[0];
            rail1_target <= s_d.target[1];
            rail_feedback_droop <= s_d.droop;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = 1'b0;

    // =====================================================================
    // Checks
    property p_shdn_quiet;
        @(posedge pclk) disable iff (!presetn)
            (s_q.top != RSQ_READY) |=> pwm_oe == '0;
    endproperty
    a_shdn_quiet: assert property (p_shdn_quiet) else $error("pwm driven outside ready");

    property p_temp_max;
        @(posedge pclk) disable iff (!presetn)
            1'b1 |=> $signed(s_q.t0) >= $signed($past(rail0_temp_input_a));
    endproperty
    a_temp_max: assert property (p_temp_max) else $error("rail0 temp below stage");

    property p_input_undervoltage_lockout_gate;
        @(posedge pclk) disable iff (!presetn)
            (s_q.top == RSQ_UVWAIT && input_voltage_sense_pin < s_q.input_undervoltage_lockout) |=> s_q.top != RSQ_READY;
    endproperty
    a_input_undervoltage_lockout_gate: assert property (p_input_undervoltage_lockout_gate) else $error("ready below input_undervoltage_lockout");

    property p_off_no_target;
        @(posedge pclk) disable iff (!presetn)
            (s_q.top != RSQ_READY) |=> s_q.target[0] == 16'h0;
    endproperty
    a_off_no_target: assert property (p_off_no_target) else $error("target while not ready");

    property p_init_len;
        @(posedge pclk) disable iff (!presetn)
            (s_q.rail[0] == RSQ_INIT) |-> s_q.cnt[0] < 32'(INIT_CYC);
    endproperty
    a_init_len: assert property (p_init_len) else $error("init overran");

    property p_save_cap;
        @(posedge pclk) disable iff (!presetn)
            s_q.saves <= 4'(`RSQ_MAX_SAVES);
    endproperty
    a_save_cap: assert property (p_save_cap) else $error("too many saves");

    property p_drop_ramp;
        @(posedge pclk) disable iff (!presetn)
            (s_q.rail[0] == RSQ_ON && !s_q.sync2_en[0] && s_q.top == RSQ_READY)
                |=> s_q.rail[0] == RSQ_RAMPDN;
    endproperty
    a_drop_ramp: assert property (p_drop_ramp) else $error("no ramp down");

    property p_profile_fixed;
        @(posedge pclk) disable iff (!presetn)
            (s_q.top == RSQ_READY) |=> $stable(s_q.prof_id);
    endproperty
    a_profile_fixed: assert property (p_profile_fixed) else $error("profile changed");

    property p_apb_one;
        @(posedge pclk) disable iff (!presetn)
            pready |=> !pready;
    endproperty
    a_apb_one: assert property (p_apb_one) else $error("pready held");
endmodule
`default_nettype wire

// [rsq_map.svh]
// Constants for the regulator start-up and temperature compensation core.
`ifndef RSQ_MAP_SVH
`define RSQ_MAP_SVH
// Register byte offsets.
`define RSQ_OFF_CTRL        12'h000
`define RSQ_OFF_STATUS      12'h004
`define RSQ_OFF_INPUT_UNDERVOLTAGE_LOCKOUT        12'h008
`define RSQ_OFF_TCOMP       12'h00c
`define RSQ_OFF_DCR         12'h010
`define RSQ_OFF_SEQ0        12'h014
`define RSQ_OFF_SEQ1        12'h018
`define RSQ_OFF_TEMP        12'h01c
`define RSQ_OFF_CUR         12'h020
`define RSQ_OFF_INCAL       12'h024
`define RSQ_OFF_INPWR       12'h028
`define RSQ_OFF_PROFILE     12'h02c
`define RSQ_OFF_SAVE        12'h030
// Field positions.
`define RSQ_CTRL_DROOP0     0
`define RSQ_CTRL_DROOP1     1
`define RSQ_STAT_SHDN       0
`define RSQ_STAT_R0ACT      1
`define RSQ_STAT_R1ACT      2
`define RSQ_STAT_PROF_LSB   4
`define RSQ_STAT_SAVES_LSB  8
// Reset values.
`define RSQ_RST_INPUT_UNDERVOLTAGE_LOCKOUT        16'h0100
`define RSQ_RST_GAIN        16'h0100
`define RSQ_RST_OFFSET      16'h0000
`define RSQ_RST_DCR25       16'h1000
`define RSQ_RST_SEQ         32'h0000_0000
// Timing and arithmetic.
`define RSQ_CLK_MHZ         125
`define RSQ_INIT_US         200
`define RSQ_INIT_CYC        (`RSQ_INIT_US * `RSQ_CLK_MHZ)
`define RSQ_TC_PPM          3900
`define RSQ_REF_DEGC        25
`define RSQ_MAX_SAVES       8
`endif

// [rsq_pkg.sv]
// Types for the regulator start-up and temperature compensation core.
`default_nettype none
package rsq_pkg;
    typedef enum logic [2:0] {
        RSQ_POR, RSQ_LOAD, RSQ_UVWAIT, RSQ_READY
    } rsq_top_type;
    typedef enum logic [2:0] {
        RSQ_OFF, RSQ_INIT, RSQ_DELAY, RSQ_RAMPUP, RSQ_ON, RSQ_RAMPDN
    } rsq_rail_type;
endpackage
`default_nettype wire

// [rsq_stage_model.sv]
// Behavioural far side: power stages, temperature sensors and enable drivers.
`default_nettype none
module rsq_stage_model (
    input wire logic pclk,
    input wire logic power_on,
    input wire logic [1:0] en_cmd,
    input wire logic [63:0] stage_set,
    input wire logic [15:0] die_set,
    output logic supply_good,
    output logic [1:0] rail_enable_pins,
    output logic [15:0] t0a,
    output logic [15:0] t0b,
    output logic [15:0] t1a,
    output logic [15:0] t1b,
    output logic [15:0] die_temp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] settle_q;
    initial begin
        settle_q = 3'h0;
        supply_good = 1'b0;
        rail_enable_pins = 2'h0;
        {t0a, t0b, t1a, t1b} = 64'h0;
        die_temp = 16'h0;
    end
    // =====================================
    // Stage outputs
    // The supply is only called good after it has settled, as a real monitor would.
    always @(posedge pclk) begin
        if (!power_on) begin
            settle_q <= 3'h0;
        end else if (settle_q != 3'h7) begin
            settle_q <= settle_q + 3'h1;
        end
        supply_good <= (settle_q == 3'h7);
        rail_enable_pins <= en_cmd;
        {t0a, t0b, t1a, t1b} <= stage_set;
        die_temp <= die_set;
    end
endmodule
`default_nettype wire

// [tb_regulator_startup_and_temp_comp.sv]
// Self-checking testbench for the start-up and temperature compensation core.
`default_nettype none
module tb_regulator_startup_and_temp_comp;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sg, core_en, tel_en, power_on;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] vin, phv, t0a, t0b, t1a, t1b, die, die_set, r0t, r1t;
    logic [2:0] code;
    logic [1:0] en_cmd, ren, droop;
    logic [6:0] pwm_out, pwm_oe;
    logic [63:0] stage_set;
    int failures, tests_run;
    rsq_core #(.INIT_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_good(sg), .input_voltage_sense_pin(vin),
        .profile_resistor_code(code), .rail_enable_pins(ren), .rail0_temp_input_a(t0a),
        .rail0_temp_input_b(t0b), .rail1_temp_input_a(t1a), .rail1_temp_input_b(t1b),
        .die_temp(die), .sensed_phase_voltage(phv), .internal_core_regulator_en(core_en),
        .telemetry_en(tel_en), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .rail0_target(r0t),
        .rail1_target(r1t), .rail_feedback_droop(droop));
    rsq_stage_model far (.pclk(pclk), .power_on(power_on), .en_cmd(en_cmd),
        .stage_set(stage_set), .die_set(die_set), .supply_good(sg), .rail_enable_pins(ren),
        .t0a(t0a), .t0b(t0b), .t1a(t1a), .t1b(t1b), .die_temp(die));
    // =====================================
    // Helpers
    task automatic results();
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] tmax(input logic [15:0] a, input logic [15:0] b);
        return ($signed(a) > $signed(b)) ? a : b;
    endfunction
    function automatic logic [2:0] exp_id(input logic [2:0] c);
        return c + 3'h1;
    endfunction
    // Current is voltage over resistance, with the voltage taken as Q8.
    function automatic logic [15:0] exp_cur(input logic [15:0] v, input logic [15:0] r);
        return 16'(({16'h0, v} << 8) / ((r == 16'h0) ? 32'h1 : {16'h0, r}));
    endfunction
    // Holds the request until pready is sampled high, then releases it on that edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic powerup(input logic [2:0] c);
        int n;
        presetn <= 1'b0;
        power_on <= 1'b0;
        vin <= 16'h0050;
        code <= c;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        power_on <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0, rd);
        check(rd[0], 32'h0);
        check({core_en, tel_en}, 32'h3);
        vin <= 16'h0101 + 16'($random(seed) & 32'h3fff);
        for (n = 0; n < 20; n++) begin
            apb(1'b0, 12'h004, 32'h0, rd);
            if (rd[0] === 1'b1) break;
        end
        check(rd[0], 32'h1);
        check(rd[6:4], exp_id(c));
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #160000;
        failures++;
        results();
    end
    // =====================================
    // Main sequence
    initial begin
        seed = 32'h324f;
        {presetn, psel, penable, pwrite, power_on} = 5'h0;
        {paddr, pwdata, vin, code, en_cmd, stage_set, die_set, phv} = '0;
        failures = 0;
        tests_run = 0;
        for (int c = 0; c < 8; c++) powerup(3'(c));
        apb(1'b0, 12'h008, 32'h0, rd);
        check(rd, 32'h0000_0100);
        apb(1'b0, 12'h00c, 32'h0, rd);
        check(rd, 32'h0000_0100);
        apb(1'b0, 12'h040, 32'h0, rd);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            stage_set <= {$random(seed), $random(seed)};
            die_set <= 16'($random(seed));
            phv <= 16'($random(seed));
            repeat (6) @(posedge pclk);
            apb(1'b0, 12'h01c, 32'h0, rd);
            check(rd[15:0], tmax(t0a, t0b));
            check(rd[31:16], tmax(t1a, t1b));
            apb(1'b0, 12'h020, 32'h0, rd);
            check(rd[31:16], die_set);
            // Zero gain, or unit gain with an offset that cancels the reading, lands on 25 degrees.
            if (i[0]) apb(1'b1, 12'h00c, {16'(16'h1900 - tmax(t0a, t0b)), 16'h0100}, rd);
            else apb(1'b1, 12'h00c, {16'h1900, 16'h0000}, rd);
            apb(1'b1, 12'h010, {16'h0, stage_set[15:0]}, rd);
            repeat (6) @(posedge pclk);
            apb(1'b0, 12'h010, 32'h0, rd);
            // At 25 degrees the resistance must come out uncorrected.
            check(rd, {stage_set[15:0], stage_set[15:0]});
            apb(1'b0, 12'h020, 32'h0, rd);
            check(rd[15:0], exp_cur(phv, stage_set[15:0]));
            apb(1'b1, 12'h000, 32'(i), rd);
            repeat (2) @(posedge pclk);
            check(droop, 32'(i));
        end
        // Output current setup is final above, so only now is input synthesis tuned.
        apb(1'b1, 12'h024, {die_set, 16'h0000}, rd);
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h028, 32'h0, rd);
        check(rd, 32'(die_set) * 32'(vin));
        for (int i = 0; i < 9; i++) apb(1'b1, 12'h030, 32'($random(seed) & 7), rd);
        apb(1'b0, 12'h004, 32'h0, rd);
        check(rd[11:8], 32'h8);
        apb(1'b1, 12'h014, 32'h0000_0001, rd);
        apb(1'b1, 12'h018, 32'h0000_0002, rd);
        check(pwm_oe, 32'h0);
        en_cmd <= 2'b11;
        repeat (100) @(posedge pclk);
        check({r0t, r1t}, 32'h0);
        for (int n = 0; n < 300 && r0t !== 16'hffff; n++) @(posedge pclk);
        check(r0t, 32'hffff);
        check(r1t, 32'h0);
        for (int n = 0; n < 300 && r1t !== 16'hffff; n++) @(posedge pclk);
        check(r1t, 32'hffff);
        apb(1'b0, 12'h004, 32'h0, rd);
        check(rd[2:1], 32'h3);
        check(pwm_oe, 32'h7f);
        check(pwm_out, 32'h0);
        en_cmd <= 2'b00;
        for (int n = 0; n < 50 && {r0t, r1t} !== 32'h0; n++) @(posedge pclk);
        repeat (4) @(posedge pclk);
        check({r0t, r1t}, 32'h0);
        check(pwm_oe, 32'h0);
        results();
    end
endmodule
`default_nettype wire
